// *** daoc_pkg.sv ***
// constants for the dual analog output control block: register map,
// conversion figures and timing counts.
// assumes a 100 MHz core clock and 16-bit register addresses.
package daoc_pkg;

   // ***************************************************************
   // register map (addresses as seen on the register port)
   // ***************************************************************
   localparam logic [15:0] ADDR_VOLT_BASE = 16'h03E8; // voltage registers, channel 0 first
   localparam logic [15:0] ADDR_BIN_BASE  = 16'hC738; // binary code registers, channel 0 first
   localparam logic [15:0] ADDR_SQW_EN    = 16'hF05C; // square wave enable, write only
   localparam logic [15:0] ADDR_CH_STRIDE = 16'h0002; // a 32-bit value spans two 16-bit registers

   // ***************************************************************
   // converter and code figures
   // ***************************************************************
   localparam int          CODE_W         = 16;         // width of a binary request
   localparam int          DAC_W          = 12;         // widest converter variant
   localparam logic [15:0] CODE_MAX       = 16'hFFFF;   // highest output level
   localparam logic [15:0] CODE_MIN       = 16'h0000;   // lowest output level, factory default
   localparam logic [13:0] VOLT_TO_CODE   = 14'h3333;   // 65535 / 5.0 V, rounded
   localparam logic [2:0]  CODE_TO_VOLT   = 3'h5;       // 5.0 V full scale
   localparam logic [15:0] SQW_HIGH_CODE  = 16'hA8F5;   // 3.3 V at 5.0 V full scale
   localparam logic [7:0]  EXP_BIAS_Q16   = 8'h6F;      // float exponent of 2^-16
   localparam logic [7:0]  EXP_SAT        = 8'h82;      // float exponent of 8.0, beyond full scale
   localparam logic [7:0]  EXP_SHIFT_REF  = 8'h86;      // exponent giving a q16 value with no shift

   // ***************************************************************
   // timing
   // ***************************************************************
   localparam longint CLK_HZ          = 100_000_000;
   localparam longint STARTUP_MS      = 100;           // factory state held after power-up
   localparam longint SQW_HZ          = 10;            // square wave frequency
   localparam longint STARTUP_CYCLES  = CLK_HZ / 1000 * STARTUP_MS;
   localparam longint SQW_HALF_CYCLES = CLK_HZ / (2 * SQW_HZ);
   localparam int     CNT_W           = 24;

endpackage

// *** daoc_top.sv ***
// register-level control of two analog output channels.
// assumes a register port driven by the device's protocol engine on
// core_clk; converter codes and enables go to the converter interface.
// the float path handles normal numbers only: denormals, infinities and
// not-a-number requests fall to the bottom rail or the top clamp by their
// sign and exponent, which is safe for an output that can only source a voltage.
`timescale 1ns/1ps

module daoc_top #(
   parameter int     DAC_BITS        = 12,
   parameter longint STARTUP_CYCLES  = daoc_pkg::STARTUP_CYCLES,
   parameter longint SQW_HALF_CYCLES = daoc_pkg::SQW_HALF_CYCLES,
   parameter logic [15:0] FULL_SCALE_CODE = daoc_pkg::CODE_MAX
)(
   input  wire logic        core_clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] reg_addr,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        stream_out_en_second,
   input  wire logic [15:0] pwrup_code_first,
   input  wire logic [15:0] pwrup_code_second,
   input  wire logic [1:0]  pwrup_disable,
   output logic      [11:0] first_analog_output,
   output logic      [11:0] second_analog_output,
   output logic      [1:0]  dac_enable
);

   // ***************************************************************
   // types and state
   // ***************************************************************
   // the factory state covers the startup hold; once it ends the block
   // stays in the run state until the next reset, so the hold happens once
   typedef enum logic [1:0] {
      ST_FACTORY = 2'b01,
      ST_RUN     = 2'b10
   } daoc_state_t;

   // everything the block remembers lives in this one record, so the
   // reset branch and the register stage below stay in step with it
   typedef struct packed {
      daoc_state_t                                  state;
      logic [daoc_pkg::CNT_W-1:0]                   startup_cnt;
      logic [daoc_pkg::CNT_W-1:0]                   sqw_cnt;
      logic                                         sqw_on;
      logic                                         sqw_high;
      logic [1:0][daoc_pkg::DAC_W-1:0]              code;
      logic [1:0]                                   en;
      logic [31:0]                                  rdata;
      logic                                         rvalid;
   } daoc_regs_t;

   // the counters compare against their last value, so one period is
   // exactly the parameter's count of cycles, end points included
   localparam int SHIFT = daoc_pkg::CODE_W - DAC_BITS;
   localparam logic [daoc_pkg::CNT_W-1:0] STARTUP_LAST = daoc_pkg::CNT_W'(STARTUP_CYCLES - 1);
   localparam logic [daoc_pkg::CNT_W-1:0] SQW_LAST     = daoc_pkg::CNT_W'(SQW_HALF_CYCLES - 1);

   daoc_regs_t cur_ff;
   daoc_regs_t nxt_cur;

   // ***************************************************************
   // conversion helpers
   // ***************************************************************
   // the request becomes volts in 3.16 fixed point, q16, by shifting the
   // mantissa by its exponent; multiplying by the code per volt and keeping
   // the upper half gives the 16-bit code directly.
   // the product keeps one spare bit so that a request just under the
   // saturation exponent cannot wrap before the clamp sees it; the clamp
   // against the full scale parameter models a supply below nominal
   // float volts to a 16-bit code, limited to the achievable full scale
   function automatic logic [15:0] volts_to_code(input logic [31:0] f);
      logic [7:0]  e;
      logic [23:0] m;
      logic [18:0] q16;
      logic [32:0] prod;
      logic [15:0] c;
      e    = f[30:23];
      m    = {1'b1, f[22:0]};
      q16  = '0;
      prod = '0;
      c    = daoc_pkg::CODE_MIN;
      // negative and tiny requests sit at the bottom rail
      if (f[31] || e < daoc_pkg::EXP_BIAS_Q16)
         q16 = '0;
      else if (e >= daoc_pkg::EXP_SAT)
         q16 = '1;
      else
         q16 = 19'(m >> (daoc_pkg::EXP_SHIFT_REF - e));
      prod = 33'(q16) * 33'(daoc_pkg::VOLT_TO_CODE);
      if (prod[32:16] > 17'(daoc_pkg::CODE_MAX))
         c = daoc_pkg::CODE_MAX;
      else
         c = prod[31:16];
      if (c > FULL_SCALE_CODE)
         c = FULL_SCALE_CODE;
      return c;
   endfunction

   // the readback multiplies the code by the full scale volts, finds the
   // leading one and normalises; single precision holds every result
   // exactly, because the product never needs more than 19 bits.
   // a zero code reads back as positive zero
   // 16-bit code back to float volts; exact enough for readback
   function automatic logic [31:0] code_to_volts(input logic [15:0] c);
      logic [18:0] q16;
      logic [4:0]  p;
      logic [41:0] sh;
      logic [31:0] f;
      q16 = 19'(c) * 19'(daoc_pkg::CODE_TO_VOLT);
      p   = '0;
      sh  = '0;
      f   = '0;
      for (int i = 0; i < 19; i++)
         if (q16[i])
            p = 5'(i);
      if (q16 != '0)
      begin
         sh = 42'(q16) << (5'd23 - p);
         f  = {1'b0, daoc_pkg::EXP_BIAS_Q16 + 8'(p), sh[22:0]};
      end
      return f;
   endfunction

   // binary value to converter code, keeping only the top bits
   // at 10-bit resolution the top two code bits stay zero on the port
   function automatic logic [daoc_pkg::DAC_W-1:0] to_dac(input logic [15:0] c);
      return daoc_pkg::DAC_W'(c >> SHIFT);
   endfunction

   // ***************************************************************
   // next-state logic
   // ***************************************************************
   // one process for the whole block so that register writes, the
   // startup switch-over and the square wave resolve in a fixed order
   always_comb
   begin
      logic        hit_volt;
      logic        hit_bin;
      logic        ch;
      logic [15:0] off;
      nxt_cur  = cur_ff;
      hit_volt = 1'b0;
      hit_bin  = 1'b0;
      ch       = 1'b0;
      off      = '0;
      nxt_cur.rvalid = 1'b0;

      // startup: factory level held, then configured state applied
      // code writes that land before the last hold cycle are taken but lost: the
      // power-up setting replaces both channels when the hold ends
      unique case (cur_ff.state)
         ST_FACTORY:
         begin
            if (cur_ff.startup_cnt == STARTUP_LAST)
            begin
               nxt_cur.state = ST_RUN;
               nxt_cur.code[0] = pwrup_disable[0] ? '0 : to_dac(pwrup_code_first);
               nxt_cur.code[1] = pwrup_disable[1] ? '0 : to_dac(pwrup_code_second);
               nxt_cur.en      = ~pwrup_disable;
            end
            else
               nxt_cur.startup_cnt = cur_ff.startup_cnt + 1'b1;
         end
         ST_RUN:
            nxt_cur.startup_cnt = cur_ff.startup_cnt;
      endcase

      // square wave: toggle each half period on the second channel
      // the wave restarts low on every enable, so its first half period is
      // a full one whatever the counter held before; the high level is a
      // fixed code, so a supply below nominal does not scale it
      if (cur_ff.sqw_on)
      begin
         if (cur_ff.sqw_cnt == SQW_LAST)
         begin
            nxt_cur.sqw_cnt  = '0;
            nxt_cur.sqw_high = ~cur_ff.sqw_high;
            nxt_cur.code[1]  = cur_ff.sqw_high ? '0 : to_dac(daoc_pkg::SQW_HIGH_CODE);
            nxt_cur.en[1]    = 1'b1;
         end
         else
            nxt_cur.sqw_cnt = cur_ff.sqw_cnt + 1'b1;
      end

      // register decode; channel chosen by the stride within each window
      // odd offsets fall on the second half of a float and stay unmapped
      if (reg_addr >= daoc_pkg::ADDR_VOLT_BASE && reg_addr < daoc_pkg::ADDR_VOLT_BASE + 16'h0004)
      begin
         off      = reg_addr - daoc_pkg::ADDR_VOLT_BASE;
         hit_volt = (off[0] == 1'b0);
         ch       = off[1];
      end
      if (reg_addr >= daoc_pkg::ADDR_BIN_BASE && reg_addr < daoc_pkg::ADDR_BIN_BASE + 16'h0004)
      begin
         off     = reg_addr - daoc_pkg::ADDR_BIN_BASE;
         hit_bin = (off[0] == 1'b0);
         ch      = off[1];
      end

      // writes come after the square wave so a write in the toggle cycle wins
      // a binary write to the second channel leaves the wave running: a voltage
      // write or a zero enable write cancels it, so the next toggle overwrites it
      if (reg_wr)
      begin
         if (hit_volt)
         begin
            nxt_cur.code[ch] = to_dac(volts_to_code(reg_wdata));
            nxt_cur.en[ch]   = 1'b1;
            if (ch)
            begin
               nxt_cur.sqw_on  = 1'b0;
               nxt_cur.sqw_cnt = '0;
            end
         end
         else if (hit_bin)
         begin
            nxt_cur.code[ch] = to_dac(reg_wdata[15:0]);
            nxt_cur.en[ch]   = 1'b1;
         end
         else if (reg_addr == daoc_pkg::ADDR_SQW_EN)
         begin
            nxt_cur.sqw_on   = (reg_wdata != '0);
            nxt_cur.sqw_cnt  = '0;
            nxt_cur.sqw_high = 1'b0;
            if (reg_wdata != '0)
            begin
               nxt_cur.code[1] = '0;
               nxt_cur.en[1]   = 1'b1;
            end
         end
      end

      // stream-out claims the channel; the square wave gives way
      // the stream request is a one-cycle pulse; it beats an enable written
      // in the same cycle, since the stream owns the channel from then on
      if (stream_out_en_second)
         nxt_cur.sqw_on = 1'b0;

      // reads: voltage registers show what the converter holds now
      // the binary and square wave registers only take writes and answer
      // zero; every read is answered one cycle on, mapped or not
      if (reg_rd)
      begin
         nxt_cur.rvalid = 1'b1;
         if (hit_volt)
            nxt_cur.rdata = code_to_volts(16'(32'(cur_ff.code[ch]) << SHIFT));
         else
            nxt_cur.rdata = '0;
      end
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   // reset puts both channels at the factory level: enabled, minimum
   // the startup hold counts from the release of reset, which stands in
   // for power-up here; a reset in mid-run restarts the hold as well,
   // and it also drops a running square wave
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cur_ff.state       <= ST_FACTORY;
         cur_ff.startup_cnt <= '0;
         cur_ff.sqw_cnt     <= '0;
         cur_ff.sqw_on      <= 1'b0;
         cur_ff.sqw_high    <= 1'b0;
         cur_ff.code        <= '0;
         cur_ff.en          <= 2'h3;
         cur_ff.rdata       <= '0;
         cur_ff.rvalid      <= 1'b0;
      end
      else
         cur_ff <= nxt_cur;
   end

   // ***************************************************************
   // outputs
   // ***************************************************************
   // every output comes straight from the state record, so the converter
   // interface sees no combinational path from the register port
   assign reg_rdata            = cur_ff.rdata;
   assign reg_rvalid           = cur_ff.rvalid;
   assign first_analog_output  = cur_ff.code[0];
   assign second_analog_output = cur_ff.code[1];
   assign dac_enable           = cur_ff.en;

endmodule

// *** daoc_top_props.sv ***
// checker for the dual analog output block: read answers, codes, startup, square wave
// assumes a bind to daoc_top at 12-bit resolution and an 8-cycle square half period
`timescale 1ns/1ps
module daoc_props #(
   parameter longint STARTUP_CYCLES = 20
)(
   input wire logic        core_clk,
   input wire logic        rst_n,
   input wire logic [15:0] reg_addr,
   input wire logic        reg_wr,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_wdata,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_rvalid,
   input wire logic        stream_out_en_second,
   input wire logic [15:0] pwrup_code_first,
   input wire logic [15:0] pwrup_code_second,
   input wire logic [1:0]  pwrup_disable,
   input wire logic [11:0] first_analog_output,
   input wire logic [11:0] second_analog_output,
   input wire logic [1:0]  dac_enable
);
   logic [31:0] cnt_ff;
   logic [31:0] wd_ff;
   logic        done;
   // cycles since reset; saturates so writes near startup end stay out of scope
   always_ff @(posedge core_clk or negedge rst_n)
   begin
      if (!rst_n) cnt_ff <= 32'h0;
      else if (cnt_ff <= STARTUP_CYCLES) cnt_ff <= cnt_ff + 32'h1;
   end
   always_ff @(posedge core_clk) wd_ff <= reg_wdata;
   assign done = (cnt_ff > STARTUP_CYCLES);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   rd_answer_a: assert property (reg_rd |=> reg_rvalid) else $error("read left unanswered");
   no_spur_a: assert property (!reg_rd |=> !reg_rvalid) else $error("answer without read");
   bin_trunc_a: assert property (done && reg_wr && reg_addr == 16'hC738
      |=> first_analog_output == wd_ff[15:4]) else $error("binary code not truncated");
   wo_read_a: assert property (reg_rd && reg_addr == 16'hC738 |=> reg_rdata == 32'h0)
      else $error("write-only register read nonzero");
   boot_hold_a: assert property (cnt_ff < STARTUP_CYCLES |-> dac_enable == 2'h3)
      else $error("factory state left early");
   boot_set_a: assert property (cnt_ff == STARTUP_CYCLES |-> dac_enable == ~pwrup_disable)
      else $error("power-up enables wrong");
   sqw_wave_a: assert property (done && reg_wr && reg_addr == 16'hF05C && reg_wdata != 0
      |=> (second_analog_output == 12'h000)[*8] ##1 (second_analog_output == 12'hA8F)[*8])
      else $error("square wave shape wrong");
   ch1_stop_a: assert property (done && reg_wr && reg_addr == 16'h03EA && reg_wdata == 0
      |=> (second_analog_output == 12'h000)[*8]) else $error("square wave kept after write");
   strm_stop_a: assert property (done && stream_out_en_second
      |-> ##2 $stable(second_analog_output)[*8]) else $error("square wave kept after stream");
   cover property (reg_rd && reg_addr == 16'h03E8);
   cover property (reg_wr && reg_addr == 16'hF05C);
   cover property (done && stream_out_en_second);
endmodule
bind daoc_top daoc_props #(.STARTUP_CYCLES(STARTUP_CYCLES)) u_daoc_props (
   .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
   .stream_out_en_second(stream_out_en_second), .pwrup_code_first(pwrup_code_first),
   .pwrup_code_second(pwrup_code_second), .pwrup_disable(pwrup_disable),
   .first_analog_output(first_analog_output), .second_analog_output(second_analog_output),
   .dac_enable(dac_enable));

// *** testbench.sv ***
// self-checking bench for the dual analog output block
// assumes daoc_top with short startup and square wave counts
`timescale 1ns/1ps
module testbench;
   logic        core_clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, stream_out_en_second = 0;
   logic [15:0] reg_addr = 16'h0;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic        reg_rvalid;
   logic [11:0] first_analog_output, second_analog_output, v;
   logic [1:0]  dac_enable, pwrup_disable = 2'h2;
   int          n_mismatch = 0, total_checks = 0, cyc = 0;
   // short counts keep the run small; expectations follow from them
   daoc_top #(.DAC_BITS(12), .STARTUP_CYCLES(20), .SQW_HALF_CYCLES(8)) u_daoc_top (
      .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .stream_out_en_second(stream_out_en_second), .pwrup_code_first(16'h8001),
      .pwrup_code_second(16'h4000), .pwrup_disable(pwrup_disable), .first_analog_output(first_analog_output),
      .second_analog_output(second_analog_output), .dac_enable(dac_enable));
   initial forever #5 core_clk = ~core_clk;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // strobe held one edge; answer read once it has landed
   task automatic rd(input logic [15:0] a, input logic [31:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk({31'h0, reg_rvalid}, 32'h1);
      chk(reg_rdata, exp);
   endtask
   task automatic t_boot;
      idle(5);
      chk({30'h0, dac_enable}, 32'h3);
      idle(20);
      chk({30'h0, dac_enable}, 32'h1);
      chk({20'h0, first_analog_output}, 32'h800);
      chk({20'h0, second_analog_output}, 32'h0);
      $display("boot test done");
   endtask
   task automatic t_binary;
      logic [15:0] codes [3] = '{16'h0000, 16'hFFFF, 16'h1234};
      foreach (codes[i])
      begin
         wr(16'hC738, {16'h0, codes[i]});
         chk({20'h0, first_analog_output}, {20'h0, codes[i][15:4]});
      end
      wr(16'hC73A, 32'hABCD);
      chk({20'h0, second_analog_output}, 32'hABC);
      rd(16'hC738, 32'h0);
      $display("binary test done");
   endtask
   task automatic t_volt;
      wr(16'h03E8, 32'h40000000);
      chk({20'h0, first_analog_output}, 32'h666);
      rd(16'h03E8, 32'h3FFFF000);
      wr(16'h03EA, 32'h40C00000);
      chk({20'h0, second_analog_output}, 32'hFFF);
      rd(16'h03EA, 32'h409FF600);
      rd(16'h03E9, 32'h0);
      $display("voltage test done");
   endtask
   // enable, then each of the three ways of stopping the wave
   task automatic t_square;
      wr(16'hF05C, 32'h1);
      idle(4);
      chk({20'h0, second_analog_output}, 32'h0);
      idle(8);
      chk({20'h0, second_analog_output}, 32'hA8F);
      idle(10);
      wr(16'h03EA, 32'h0);
      idle(20);
      chk({20'h0, second_analog_output}, 32'h0);
      wr(16'hF05C, 32'h1);
      idle(20);
      @(posedge core_clk);
      stream_out_en_second <= 1'b1;
      @(posedge core_clk);
      stream_out_en_second <= 1'b0;
      idle(2);
      v = second_analog_output;
      // any eight cycles of a running wave hold exactly one toggle
      idle(8);
      chk({20'h0, second_analog_output}, {20'h0, v});
      idle(8);
      chk({20'h0, second_analog_output}, {20'h0, v});
      wr(16'hF05C, 32'h1);
      idle(20);
      wr(16'hF05C, 32'h0);
      idle(1);
      v = second_analog_output;
      idle(8);
      chk({20'h0, second_analog_output}, {20'h0, v});
      idle(8);
      chk({20'h0, second_analog_output}, {20'h0, v});
      $display("square wave test done");
   endtask
   // mid-run reset with the first channel disabled at power-up instead
   task automatic t_reset;
      @(posedge core_clk);
      rst_n <= 1'b0;
      pwrup_disable <= 2'h1;
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      #1;
      chk({30'h0, dac_enable}, 32'h3);
      chk({20'h0, second_analog_output}, 32'h0);
      idle(19);
      chk({30'h0, dac_enable}, 32'h3);
      idle(1);
      chk({30'h0, dac_enable}, 32'h2);
      chk({20'h0, first_analog_output}, 32'h0);
      chk({20'h0, second_analog_output}, 32'h400);
      $display("reset test done");
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // a hang ends the run; the tests need well under 1000 cycles
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         n_mismatch++;
         conclude();
      end
   end
   initial
   begin
      repeat (3) @(posedge core_clk);
      rst_n <= 1'b1;
      t_boot();
      t_binary();
      t_volt();
      t_square();
      t_reset();
      conclude();
   end
endmodule
